// File: shared/scr_defs.svh
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH
// Function
// - low four word bits pick the register; 0000 to 0100 reach registers 0 to 4
// - register 0 write with bit 21 set starts band calibration, else band kept
// - register 0 bit 20 picks prescaler 4/5 or 8/9
// - register 1 bits 27:4 hold the 24-bit main fraction numerator
// - auxiliary fraction and modulus are upper part times 2^14 plus lower part
// - buffered fields wait in a shadow stage until register 0 is written
// - register 0 write resets the modulator unless register 3 bit 30 is set
// - register 3 bit 29 enables output phase resynchronisation
// - with register 3 bit 28 set each register 0 write adds the phase value
// - register 4 bit 26 doubles the reference, both reference edges active
// - register 4 bit 25 adds a toggle divide-by-two after the R counter
// - a 10-bit R counter divides the reference by 1 to 1023
// - register 4 bit 14 enables shadowing of the output divider select
// - register 4 bit 8 picks multiplexer output level, 1.8 V or 3.3 V
// - register 4 bit 7 sets phase detector polarity, one is positive
// - register 4 bit 6 powers down; registers and serial loading stay alive
// - register 4 bit 5 forces the charge pump into three-state
// - register 4 bit 4 holds N counter, R counter and band select in reset
// - when shadowing, register 6 bits 23:21 apply at next register 0 write

// ==========================================
// register addresses
`define SCR_A_R0     4'h0
`define SCR_A_R1     4'h1
`define SCR_A_R2     4'h2
`define SCR_A_R3     4'h3
`define SCR_A_R4     4'h4
`define SCR_A_R5     4'h5
`define SCR_A_R6     4'h6
`define SCR_A_R13    4'hD
// ==========================================
// register 0 fields
`define SCR_CAL_BIT  21
`define SCR_PRE_BIT  20
`define SCR_INT_HI   19
`define SCR_INT_LO   4
// register 1 field
`define SCR_F1_HI    27
`define SCR_F1_LO    4
// registers 2 and 13 fields
`define SCR_AUXF_HI  31
`define SCR_AUXF_LO  18
`define SCR_AUXM_HI  17
`define SCR_AUXM_LO  4
// register 3 fields
`define SCR_SDD_BIT  30
`define SCR_RSY_BIT  29
`define SCR_PST_BIT  28
`define SCR_PH_HI    27
`define SCR_PH_LO    4
// register 4 fields
`define SCR_MUX_HI   29
`define SCR_MUX_LO   27
`define SCR_DBL_BIT  26
`define SCR_HLV_BIT  25
`define SCR_RC_HI    24
`define SCR_RC_LO    15
`define SCR_SHD_BIT  14
`define SCR_CP_HI    13
`define SCR_CP_LO    10
`define SCR_LVL_BIT  8
`define SCR_POL_BIT  7
`define SCR_PD_BIT   6
`define SCR_TRI_BIT  5
`define SCR_CRS_BIT  4
// register 6 field
`define SCR_DIV_HI   23
`define SCR_DIV_LO   21
// ==========================================
// reset values
`define SCR_RC_RST   10'h001
`define SCR_POL_RST  1'b1
`endif

// File: shared/scr_pkg.sv
package scr_pkg;
  typedef logic [31:0] scr_word_t;
  typedef logic [23:0] scr_phase_t;
  typedef logic [13:0] scr_half_t;
  typedef logic [27:0] scr_aux_t;
  typedef logic [9:0]  scr_rdiv_t;
endpackage

// File: logic/scr_ref_path.sv
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_ref_path
  import scr_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst_n,
  input  wire logic      ref_level,
  input  wire logic      doubler_en,
  input  wire logic      halver_en,
  input  wire scr_rdiv_t r_div,
  input  wire logic      hold,
  output logic           pfd_ref_ff
);
  logic      prev_ff;
  logic      half_ff;
  scr_rdiv_t cnt_ff;
  logic      edge_seen;
  logic      tick;
  scr_rdiv_t r_last;

  // ==========================================
  // edge select and terminal count
  always_comb begin
    edge_seen = doubler_en ? (ref_level ^ prev_ff) : (prev_ff & ~ref_level);
    r_last    = (r_div == 10'h000) ? 10'h000 : r_div - 10'h001;
    tick      = edge_seen && (cnt_ff >= r_last);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) prev_ff <= 1'b0;
    else        prev_ff <= ref_level;
  end

  // ==========================================
  // R counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)         cnt_ff <= 10'h000;
    else if (hold)      cnt_ff <= 10'h000;
    else if (tick)      cnt_ff <= 10'h000;
    else if (edge_seen) cnt_ff <= cnt_ff + 10'h001;
  end

  // ==========================================
  // toggle stage and output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)    half_ff <= 1'b0;
    else if (hold) half_ff <= 1'b0;
    else if (tick) half_ff <= ~half_ff;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)         pfd_ref_ff <= 1'b0;
    else if (hold)      pfd_ref_ff <= 1'b0;
    else if (halver_en) pfd_ref_ff <= tick ? ~half_ff : half_ff;
    else                pfd_ref_ff <= tick;
  end

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_tick_wraps;
    tick && !hold |=> cnt_ff == 10'h000;
  endproperty
  a_tick_wraps: assert property (p_tick_wraps) else $error("R counter did not wrap");

  property p_both_edges;
    doubler_en && !hold && (ref_level != prev_ff) && (cnt_ff < r_last)
      |=> cnt_ff == 10'($past(cnt_ff) + 10'h001);
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("doubled edge not counted");

  property p_halver_level;
    halver_en && !hold |=> pfd_ref_ff == half_ff;
  endproperty
  a_halver_level: assert property (p_halver_level) else $error("halver output wrong");
endmodule

// File: logic/scr_config_regs.sv
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_config_regs
  import scr_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  input  wire logic  prog_clk,
  input  wire logic  prog_data,
  input  wire logic  prog_load,
  input  wire logic  reference_input,
  output logic [15:0] integer_divide_ff,
  output logic        prescaler_select_ff,
  output logic        vco_band_calibration_ff,
  output scr_phase_t  main_fraction_numerator_ff,
  output scr_aux_t    auxiliary_fraction_ff,
  output scr_aux_t    auxiliary_modulus_ff,
  output logic        modulator_reset_ff,
  output logic        phase_resync_enable_ff,
  output logic        resync_start_ff,
  output scr_phase_t  phase_offset_ff,
  output logic [2:0]  test_output_multiplexer_ff,
  output logic [3:0]  pump_current_ff,
  output logic        output_level_select_ff,
  output logic        detector_polarity_ff,
  output logic        pump_hiz_ff,
  output logic        vco_power_ff,
  output logic        lock_detect_clear_ff,
  output logic        rf_outputs_enable_ff,
  output logic        counter_hold_ff,
  output logic        band_select_reset_ff,
  output logic [2:0]  rf_divider_select_ff,
  output logic        pfd_reference_ff
);
  // ==========================================
  // reset release
  logic rst_s1_ff;
  logic rst_n_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // ==========================================
  // pin synchronisers
  logic [2:0] pclk_ff;
  logic [2:0] load_ff;
  logic [1:0] data_ff;
  logic [1:0] ref_ff;

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pclk_ff <= 3'h0;
      load_ff <= 3'h0;
      data_ff <= 2'h0;
      ref_ff  <= 2'h0;
    end else begin
      pclk_ff <= {pclk_ff[1:0], prog_clk};
      load_ff <= {load_ff[1:0], prog_load};
      data_ff <= {data_ff[0], prog_data};
      ref_ff  <= {ref_ff[0], reference_input};
    end
  end

  logic pclk_rise;
  logic load_rise;
  assign pclk_rise = pclk_ff[1] & ~pclk_ff[2];
  assign load_rise = load_ff[1] & ~load_ff[2];

  // ==========================================
  // serial shift register
  scr_word_t shift_ff;

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff)      shift_ff <= 32'h0000_0000;
    else if (pclk_rise) shift_ff <= {shift_ff[30:0], data_ff[1]};
  end

  // ==========================================
  // address decode
  logic [3:0] addr;
  logic       w0;
  logic       w1;
  logic       w2;
  logic       w3;
  logic       w4;
  logic       w6;
  logic       w13;

  assign addr = shift_ff[3:0];
  assign w0   = load_rise && (addr == `SCR_A_R0);
  assign w1   = load_rise && (addr == `SCR_A_R1);
  assign w2   = load_rise && (addr == `SCR_A_R2);
  assign w3   = load_rise && (addr == `SCR_A_R3);
  assign w4   = load_rise && (addr == `SCR_A_R4);
  assign w6   = load_rise && (addr == `SCR_A_R6);
  assign w13  = load_rise && (addr == `SCR_A_R13);

  // ==========================================
  // shadow stage
  scr_phase_t frac_stg_ff;
  scr_half_t  auxf_lo_stg_ff;
  scr_half_t  auxm_lo_stg_ff;
  scr_half_t  auxf_hi_stg_ff;
  scr_half_t  auxm_hi_stg_ff;
  scr_phase_t phase_stg_ff;
  scr_rdiv_t  rdiv_stg_ff;
  logic       dbl_stg_ff;
  logic       hlv_stg_ff;
  logic [3:0] cp_stg_ff;
  logic [2:0] div_stg_ff;

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      frac_stg_ff    <= 24'h00_0000;
      auxf_lo_stg_ff <= 14'h0000;
      auxm_lo_stg_ff <= 14'h0000;
      auxf_hi_stg_ff <= 14'h0000;
      auxm_hi_stg_ff <= 14'h0000;
      phase_stg_ff   <= 24'h00_0000;
      rdiv_stg_ff    <= `SCR_RC_RST;
      dbl_stg_ff     <= 1'b0;
      hlv_stg_ff     <= 1'b0;
      cp_stg_ff      <= 4'h0;
      div_stg_ff     <= 3'h0;
    end else begin
      if (w1) frac_stg_ff <= shift_ff[`SCR_F1_HI:`SCR_F1_LO];
      if (w2) begin
        auxf_lo_stg_ff <= shift_ff[`SCR_AUXF_HI:`SCR_AUXF_LO];
        auxm_lo_stg_ff <= shift_ff[`SCR_AUXM_HI:`SCR_AUXM_LO];
      end
      if (w13) begin
        auxf_hi_stg_ff <= shift_ff[`SCR_AUXF_HI:`SCR_AUXF_LO];
        auxm_hi_stg_ff <= shift_ff[`SCR_AUXM_HI:`SCR_AUXM_LO];
      end
      if (w3) phase_stg_ff <= shift_ff[`SCR_PH_HI:`SCR_PH_LO];
      if (w4) begin
        rdiv_stg_ff <= shift_ff[`SCR_RC_HI:`SCR_RC_LO];
        dbl_stg_ff  <= shift_ff[`SCR_DBL_BIT];
        hlv_stg_ff  <= shift_ff[`SCR_HLV_BIT];
        cp_stg_ff   <= shift_ff[`SCR_CP_HI:`SCR_CP_LO];
      end
      if (w6) div_stg_ff <= shift_ff[`SCR_DIV_HI:`SCR_DIV_LO];
    end
  end

  // ==========================================
  // immediate control bits
  logic sd_dis_ff;
  logic pstep_ff;
  logic shadow_en_ff;
  logic pd_ff;
  logic tri_ff;
  logic crst_ff;

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sd_dis_ff                  <= 1'b0;
      phase_resync_enable_ff     <= 1'b0;
      pstep_ff                   <= 1'b0;
      test_output_multiplexer_ff <= 3'h0;
      shadow_en_ff               <= 1'b0;
      output_level_select_ff     <= 1'b0;
      detector_polarity_ff       <= `SCR_POL_RST;
      pd_ff                      <= 1'b0;
      tri_ff                     <= 1'b0;
      crst_ff                    <= 1'b0;
    end else begin
      if (w3) begin
        sd_dis_ff              <= shift_ff[`SCR_SDD_BIT];
        phase_resync_enable_ff <= shift_ff[`SCR_RSY_BIT];
        pstep_ff               <= shift_ff[`SCR_PST_BIT];
      end
      if (w4) begin
        test_output_multiplexer_ff <= shift_ff[`SCR_MUX_HI:`SCR_MUX_LO];
        shadow_en_ff               <= shift_ff[`SCR_SHD_BIT];
        output_level_select_ff     <= shift_ff[`SCR_LVL_BIT];
        detector_polarity_ff       <= shift_ff[`SCR_POL_BIT];
        pd_ff                      <= shift_ff[`SCR_PD_BIT];
        tri_ff                     <= shift_ff[`SCR_TRI_BIT];
        crst_ff                    <= shift_ff[`SCR_CRS_BIT];
      end
    end
  end

  // ==========================================
  // register 0 write: frequency word and shadow transfer
  scr_rdiv_t r_div_ff;
  logic      dbl_ff;
  logic      hlv_ff;

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      integer_divide_ff          <= 16'h0000;
      prescaler_select_ff        <= 1'b0;
      main_fraction_numerator_ff <= 24'h00_0000;
      auxiliary_fraction_ff      <= 28'h000_0000;
      auxiliary_modulus_ff       <= 28'h000_0000;
      r_div_ff                   <= `SCR_RC_RST;
      dbl_ff                     <= 1'b0;
      hlv_ff                     <= 1'b0;
      pump_current_ff            <= 4'h0;
    end else if (w0) begin
      integer_divide_ff          <= shift_ff[`SCR_INT_HI:`SCR_INT_LO];
      prescaler_select_ff        <= shift_ff[`SCR_PRE_BIT];
      main_fraction_numerator_ff <= frac_stg_ff;
      auxiliary_fraction_ff      <= {auxf_hi_stg_ff, auxf_lo_stg_ff};
      auxiliary_modulus_ff       <= {auxm_hi_stg_ff, auxm_lo_stg_ff};
      r_div_ff                   <= rdiv_stg_ff;
      dbl_ff                     <= dbl_stg_ff;
      hlv_ff                     <= hlv_stg_ff;
      pump_current_ff            <= cp_stg_ff;
    end
  end

  // ==========================================
  // register 0 write side effects
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      vco_band_calibration_ff <= 1'b0;
      modulator_reset_ff      <= 1'b0;
      resync_start_ff         <= 1'b0;
    end else begin
      vco_band_calibration_ff <= w0 & shift_ff[`SCR_CAL_BIT];
      modulator_reset_ff      <= w0 & ~sd_dis_ff;
      resync_start_ff         <= w0 & phase_resync_enable_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff)                             phase_offset_ff <= 24'h00_0000;
    else if (w0 && pstep_ff)                   phase_offset_ff <= phase_offset_ff + phase_stg_ff;
    else if (w0 && phase_resync_enable_ff)     phase_offset_ff <= phase_stg_ff;
  end

  // ==========================================
  // output divider select
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff)                 rf_divider_select_ff <= 3'h0;
    else if (w6 && !shadow_en_ff)  rf_divider_select_ff <= shift_ff[`SCR_DIV_HI:`SCR_DIV_LO];
    else if (w0 && shadow_en_ff)   rf_divider_select_ff <= div_stg_ff;
  end

  // ==========================================
  // power-down, three-state and counter reset
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pump_hiz_ff          <= 1'b0;
      vco_power_ff         <= 1'b0;
      lock_detect_clear_ff <= 1'b1;
      rf_outputs_enable_ff <= 1'b0;
      counter_hold_ff      <= 1'b1;
      band_select_reset_ff <= 1'b1;
    end else begin
      pump_hiz_ff          <= pd_ff | tri_ff;
      vco_power_ff         <= ~pd_ff;
      lock_detect_clear_ff <= pd_ff;
      rf_outputs_enable_ff <= ~pd_ff;
      counter_hold_ff      <= pd_ff | crst_ff;
      band_select_reset_ff <= crst_ff;
    end
  end

  // ==========================================
  // reference path
  scr_ref_path u_ref_path (
    .core_clk   (core_clk),
    .rst_n      (rst_n_ff),
    .ref_level  (ref_ff[1]),
    .doubler_en (dbl_ff),
    .halver_en  (hlv_ff),
    .r_div      (r_div_ff),
    .hold       (counter_hold_ff),
    .pfd_ref_ff (pfd_reference_ff)
  );

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_ff);

  property p_shift_msb_first;
    pclk_rise |=> shift_ff[0] == $past(data_ff[1]) && shift_ff[31:1] == $past(shift_ff[30:0]);
  endproperty
  a_shift_msb_first: assert property (p_shift_msb_first) else $error("shift order wrong");

  property p_int_load;
    w0 |=> integer_divide_ff == $past(shift_ff[19:4]) && prescaler_select_ff == $past(shift_ff[20]);
  endproperty
  a_int_load: assert property (p_int_load) else $error("register 0 fields not loaded");

  property p_decode_excl;
    w1 |=> $stable(integer_divide_ff);
  endproperty
  a_decode_excl: assert property (p_decode_excl) else $error("address decode overlap");

  property p_cal;
    w0 |=> vco_band_calibration_ff == $past(shift_ff[`SCR_CAL_BIT]) ##1 !vco_band_calibration_ff;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration pulse wrong");

  property p_shadow_hold;
    w1 |=> $stable(main_fraction_numerator_ff);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("fraction applied early");

  property p_aux_form;
    w0 |=> auxiliary_fraction_ff == {$past(auxf_hi_stg_ff), $past(auxf_lo_stg_ff)};
  endproperty
  a_aux_form: assert property (p_aux_form) else $error("aux fraction wrong");

  property p_sd_reset;
    w0 |=> modulator_reset_ff == !$past(sd_dis_ff);
  endproperty
  a_sd_reset: assert property (p_sd_reset) else $error("modulator reset wrong");

  property p_phase_step;
    w0 && pstep_ff |=> phase_offset_ff == 24'($past(phase_offset_ff) + $past(phase_stg_ff));
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase step wrong");

  sequence s_pd_write;
    w4 && shift_ff[`SCR_PD_BIT];
  endsequence
  sequence s_pd_state;
    !vco_power_ff && pump_hiz_ff && lock_detect_clear_ff && !rf_outputs_enable_ff
      && counter_hold_ff;
  endsequence
  property p_power_down;
    s_pd_write |-> ##2 s_pd_state;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down effects missing");

  property p_tristate;
    w4 && shift_ff[`SCR_TRI_BIT] |-> ##2 pump_hiz_ff;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pump not three-state");

  property p_counter_reset;
    w4 && shift_ff[`SCR_CRS_BIT] |-> ##2 (counter_hold_ff && band_select_reset_ff);
  endproperty
  a_counter_reset: assert property (p_counter_reset) else $error("counters not held");

  property p_div_shadow;
    w6 && shadow_en_ff |=> $stable(rf_divider_select_ff);
  endproperty
  a_div_shadow: assert property (p_div_shadow) else $error("divider applied early");
endmodule

// File: testbench/scr_host_model.sv
`timescale 1ns/1ps
// ==========================================
// host side of the three-wire programming link
module scr_host_model (
  input  wire logic core_clk,
  output logic      prog_clk,
  output logic      prog_data,
  output logic      prog_load
);
  initial begin
    prog_clk  = 1'h0;
    prog_data = 1'h0;
    prog_load = 1'h0;
  end
  // ==========================================
  // one word, msb first, clock held high 3 cycles and low 4 cycles
  task automatic send(input logic [31:0] word);
    for (int i = 31; i >= 0; i--) begin
      @(posedge core_clk);
      prog_data <= word[i];
      repeat (3) @(posedge core_clk);
      prog_clk <= 1'h1;
      repeat (3) @(posedge core_clk);
      prog_clk <= 1'h0;
    end
    repeat (3) @(posedge core_clk);
    prog_load <= 1'h1;
    prog_data <= ~word[0];
    repeat (4) @(posedge core_clk);
    prog_load <= 1'h0;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import scr_pkg::*;
;
  // ==========================================
  // stimulus and observed signals
  logic        core_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        reference_input = 1'h0;
  logic [1:0]  ref_div = 2'h0;
  wire         prog_clk, prog_data, prog_load;
  logic [15:0] int_div;
  logic        pre_sel, cal_p, mrst_p, rsy_en, rsy_p, lvl, pol, hiz, vco_on;
  logic        ld_clr, rf_en, hold, bs_rst, pfd, pfd_q;
  scr_phase_t  frac, ofs;
  scr_aux_t    auxf, auxm;
  logic [2:0]  mux, div;
  logic [3:0]  cp;
  int          error_cnt = 0, checks = 0, cyc = 0;
  int          cal_cnt = 0, mrst_cnt = 0, rsy_cnt = 0, pfd_cnt = 0;

  always #12.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    ref_div <= ref_div + 2'h1;
    if (ref_div == 2'h3) reference_input <= ~reference_input;
  end

  // ==========================================
  // pulse counters and timeout
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cal_p === 1'h1) cal_cnt++;
    if (mrst_p === 1'h1) mrst_cnt++;
    if (rsy_p === 1'h1) rsy_cnt++;
    if (pfd === 1'h1 && pfd_q === 1'h0) pfd_cnt++;
    pfd_q <= pfd;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end
  end

  scr_host_model host (.core_clk(core_clk), .prog_clk(prog_clk), .prog_data(prog_data),
                       .prog_load(prog_load));

  scr_config_regs uut (
    .core_clk(core_clk), .rst_n(rst_n), .prog_clk(prog_clk), .prog_data(prog_data),
    .prog_load(prog_load), .reference_input(reference_input), .integer_divide_ff(int_div),
    .prescaler_select_ff(pre_sel), .vco_band_calibration_ff(cal_p),
    .main_fraction_numerator_ff(frac), .auxiliary_fraction_ff(auxf),
    .auxiliary_modulus_ff(auxm), .modulator_reset_ff(mrst_p), .phase_resync_enable_ff(rsy_en),
    .resync_start_ff(rsy_p), .phase_offset_ff(ofs), .test_output_multiplexer_ff(mux),
    .pump_current_ff(cp), .output_level_select_ff(lvl), .detector_polarity_ff(pol),
    .pump_hiz_ff(hiz), .vco_power_ff(vco_on), .lock_detect_clear_ff(ld_clr),
    .rf_outputs_enable_ff(rf_en), .counter_hold_ff(hold), .band_select_reset_ff(bs_rst),
    .rf_divider_select_ff(div), .pfd_reference_ff(pfd));

  // ==========================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input scr_word_t w);
    host.send(w);
    repeat (6) @(posedge core_clk);
  endtask

  task automatic clr();
    @(negedge core_clk);
    cal_cnt = 0;
    mrst_cnt = 0;
    rsy_cnt = 0;
    pfd_cnt = 0;
  endtask

  function automatic scr_word_t r0(input logic [15:0] n, input logic pre, input logic cal);
    return {10'h000, cal, pre, n, 4'h0};
  endfunction

  function automatic scr_word_t w3(input logic [2:0] m, input scr_phase_t ph);
    return {1'h0, m, ph, 4'h3};
  endfunction

  function automatic scr_word_t w4(input logic [2:0] mx, input logic [1:0] dh,
                                   input logic [9:0] rc, input logic [10:0] b);
    return {2'h0, mx, dh, rc, b, 4'h4};
  endfunction

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_reg0();
    check(pol, 1'h1);
    check(vco_on, 1'h1);
    clr();
    wr(r0(16'h004B, 1'h1, 1'h1));
    check(int_div, 16'h004B);
    check(pre_sel, 1'h1);
    check(cal_cnt, 1);
    check(mrst_cnt, 1);
    clr();
    wr(r0(16'h7FFF, 1'h0, 1'h0));
    check(int_div, 16'h7FFF);
    check(pre_sel, 1'h0);
    check(cal_cnt, 0);
    check(mrst_cnt, 1);
    done("register0");
  endtask

  task automatic t_frac();
    wr({4'h0, 24'hABCDEF, 4'h1});
    wr({14'h1234, 14'h2AAA, 4'h2});
    wr({14'h0005, 14'h0007, 4'hD});
    check(frac, 24'h000000);
    check(auxf, 28'h0);
    wr(r0(16'h0017, 1'h0, 1'h0));
    check(frac, 24'hABCDEF);
    check(auxf, {14'h0005, 14'h1234});
    check(auxm, {14'h0007, 14'h2AAA});
    done("fraction");
  endtask

  task automatic t_phase();
    wr(w3(3'h5, 24'h800001));
    clr();
    wr(r0(16'h0017, 1'h0, 1'h0));
    check(ofs, 24'h800001);
    wr(r0(16'h0017, 1'h0, 1'h0));
    check(ofs, 24'h000002);
    check(mrst_cnt, 0);
    wr(w3(3'h2, 24'h123456));
    check(rsy_en, 1'h1);
    clr();
    wr(r0(16'h0017, 1'h0, 1'h0));
    wr(r0(16'h0017, 1'h0, 1'h0));
    check(ofs, 24'h123456);
    check(rsy_cnt, 2);
    check(mrst_cnt, 2);
    done("phase");
  endtask

  task automatic t_addr();
    clr();
    wr(32'h00800025);
    wr({28'hFFFFFFF, 4'hC});
    check(int_div, 16'h0017);
    check(cal_cnt + mrst_cnt, 0);
    done("address");
  endtask

  task automatic t_reg4();
    wr(w4(3'h0, 2'h0, 10'h004, {1'h1, 4'hB, 6'h10}));
    check(lvl, 1'h1);
    check(pol, 1'h0);
    check(cp, 4'h0);
    wr({8'h00, 3'h5, 17'h0, 4'h6});
    check(div, 3'h0);
    wr(r0(16'h0017, 1'h0, 1'h0));
    check(cp, 4'hB);
    check(div, 3'h5);
    wr(w4(3'h0, 2'h0, 10'h004, {1'h0, 4'hB, 6'h18}));
    check(pol, 1'h1);
    wr({8'h00, 3'h3, 17'h0, 4'h6});
    check(div, 3'h3);
    done("register4");
  endtask

  task automatic t_status();
    wr(w4(3'h0, 2'h0, 10'h004, {1'h0, 4'hB, 6'h14}));
    check({hiz, vco_on, ld_clr, rf_en, hold, bs_rst}, 6'h2A);
    wr({4'h0, 24'h000F0F, 4'h1});
    wr(r0(16'h0017, 1'h0, 1'h0));
    check(frac, 24'h000F0F);
    wr(w4(3'h0, 2'h0, 10'h004, {1'h0, 4'hB, 6'h12}));
    check({hiz, vco_on, hold}, 3'h6);
    wr(w4(3'h0, 2'h0, 10'h004, {1'h0, 4'hB, 6'h11}));
    check({hiz, hold, bs_rst}, 3'h3);
    done("status");
  endtask

  task automatic t_ref();
    logic [1:0] dh[3] = '{2'h0, 2'h2, 2'h1};
    int         ex[3] = '{10, 20, 5};
    for (int k = 0; k < 3; k++) begin
      wr(w4(3'h0, dh[k], 10'h004, {1'h0, 4'hB, 6'h10}));
      wr(r0(16'h0017, 1'h0, 1'h0));
      clr();
      repeat (320) @(posedge core_clk);
      check(pfd_cnt >= ex[k] - 1 && pfd_cnt <= ex[k] + 1, 1'h1);
    end
    wr(w4(3'h5, 2'h0, 10'h004, {1'h0, 4'hB, 6'h10}));
    check(mux, 3'h5);
    done("reference");
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge core_clk);
    t_reg0();
    t_frac();
    t_phase();
    t_addr();
    t_reg4();
    t_status();
    t_ref();
    finish_test();
  end
endmodule
